// File: rtl/wrf_consts.vh
// Constants of the wake-on-LAN receive filter
// Assumes APB byte addresses equal register index times four
`ifndef WRF_CONSTS_VH
`define WRF_CONSTS_VH
// -----------------------------------------------
// Register indexes (byte address = index * 4)
// -----------------------------------------------
`define WRF_IDX_CFG 14'h04A0
`define WRF_IDX_ST 14'h04A1
`define WRF_IDX_DATA0 14'h04A2
`define WRF_IDX_DATA9 14'h04AB
`define WRF_IDX_IRQ_ST 14'h04C0
`define WRF_IDX_IRQ_MASK 14'h04C1
// -----------------------------------------------
// Field positions and reset values
// -----------------------------------------------
`define WRF_CFG_RESET 16'h1000
`define WRF_CFG_WMASK 16'hF7FF
`define WRF_CFG_SFD 13
`define WRF_CFG_CRC_GATE 12
`define WRF_CFG_LVL_CLR 11
`define WRF_CFG_IND_SEL 8
`define WRF_CFG_WOL_EN 7
`define WRF_CFG_PASS_EN 5
`define WRF_CFG_PAT_EN 1
`define WRF_CFG_MAGIC_EN 0
`define WRF_ST_SRC 12
`define WRF_ST_SFD_ERR 7
`define WRF_ST_CRC_ERR 6
`define WRF_ST_HACK 5
`define WRF_ST_PAT 1
`define WRF_ST_MAGIC 0
`define WRF_ST_EVT_MASK 16'h00E3
`define WRF_DATA_RESET 16'h0000
// -----------------------------------------------
// Frame bytes and counts
// -----------------------------------------------
`define WRF_SFD_NORMAL 8'hD5
`define WRF_SFD_SWAPPED 8'h5D
`define WRF_PREAMBLE 8'h55
`define WRF_SYNC_BYTE 8'hFF
`define WRF_SYNC_LAST 3'h5
`define WRF_ADDR_LAST 3'h5
`define WRF_BODY_LAST 7'h5F
`define WRF_PW_LAST 3'h5
`define WRF_PAT_BYTES 4'h8
// -----------------------------------------------
// Timing
// -----------------------------------------------
`define WRF_REF_PERIOD_PS 8000
`define WRF_CLK_PERIOD_PS 25000
`define WRF_PULSE_BASE 8
`endif

// File: rtl/wrf_wol_rx_filter.v
// Wake-on-LAN receive filter with APB register slave
// Expects received bytes synchronous to clk_sys, one per valid
// strobe, frame end as a one-cycle pulse with its CRC verdict
`timescale 1ns/1ps
`default_nettype none
`include "wrf_consts.vh"

module wrf_wol_rx_filter
(
    input wire clk_sys,
    input wire rst_b,
    input wire clkEn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rxByteValid,
    input wire [7:0] rxByte,
    input wire rxFrameEnd,
    input wire rxCrcBad,
    input wire polarityIrq,
    output reg wakeOut,
    output reg irqOut,
    output reg intRouteOut
);

    // -----------------------------------------------
    // Helpers
    // -----------------------------------------------
    localparam F_HUNT = 2'd0;
    localparam F_BODY = 2'd1;
    localparam F_DROP = 2'd2;
    localparam M_SYNC = 2'd0;
    localparam M_ADDR = 2'd1;
    localparam M_PASS = 2'd2;
    localparam M_DONE = 2'd3;

    function [7:0] reorder;
        input [1:0] mode;
        input [7:0] b;
        begin
            case (mode)
                2'b00: reorder = b;
                2'b01: reorder = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
                2'b10: reorder = {b[3:0], b[7:4]};
                2'b11: reorder = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
                default: reorder = b;
            endcase
        end
    endfunction

    // Reference cycles scaled to clk_sys, rounded up
    function [4:0] pulseLen;
        input [1:0] sel;
        integer t;
        begin
            t = ((`WRF_PULSE_BASE << sel) * `WRF_REF_PERIOD_PS + `WRF_CLK_PERIOD_PS - 1)
                / `WRF_CLK_PERIOD_PS;
            pulseLen = t[4:0];
        end
    endfunction

    function isMapped;
        input [13:0] idx;
        begin
            isMapped = (idx >= `WRF_IDX_CFG && idx <= `WRF_IDX_DATA9)
                || idx == `WRF_IDX_IRQ_ST || idx == `WRF_IDX_IRQ_MASK;
        end
    endfunction

    // -----------------------------------------------
    // APB decode
    // -----------------------------------------------
    wire [13:0] idx = paddr[15:2];
    wire [13:0] dataOff = idx - `WRF_IDX_DATA0;
    wire mapped = (paddr[1:0] == 2'h0) && isMapped(idx);
    wire access = psel && penable;
    wire wrEn = access && pwrite && mapped;
    wire rdDone = access && !pwrite && mapped;

    // Zero wait states; read data is captured in the setup cycle
    assign pready = access;
    assign pslverr = access && !mapped;

    reg [15:0] cfg;
    reg srcSel;
    reg [15:0] rxStat;
    reg [15:0] irqStat;
    reg [15:0] irqMask;
    wire [159:0] dataVec;

    // Address, password and pattern words
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1)
        begin : gen_data
            reg [15:0] word;
            always @(posedge clk_sys)
            begin
                if (!rst_b)
                    word <= `WRF_DATA_RESET;
                else if (clkEn && wrEn && dataOff == g)
                    word <= pwdata[15:0];
            end
            assign dataVec[g*16 +: 16] = word;
        end
    endgenerate

    wire [47:0] macVec = dataVec[47:0];
    wire [47:0] pwVec = dataVec[95:48];
    wire [63:0] patVec = dataVec[159:96];

    wire wolEn = cfg[`WRF_CFG_WOL_EN];

    // Configuration and source select; level-clear never stored
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cfg <= `WRF_CFG_RESET;
            srcSel <= 1'b0;
        end
        else if (clkEn && wrEn)
        begin
            if (idx == `WRF_IDX_CFG)
            begin
                cfg <= pwdata[15:0] & `WRF_CFG_WMASK;
                if (pwdata[`WRF_CFG_WOL_EN] && !wolEn)
                    srcSel <= 1'b1;
            end
            if (idx == `WRF_IDX_ST)
                srcSel <= pwdata[`WRF_ST_SRC];
        end
    end

    // Read mux, sampled in setup so data stands in access
    reg [15:0] rdVal;
    always @*
    begin
        rdVal = 16'h0000;
        if (idx == `WRF_IDX_CFG)
            rdVal = cfg;
        else if (idx == `WRF_IDX_ST)
            rdVal = rxStat | ({15'h0000, srcSel} << `WRF_ST_SRC);
        else if (idx == `WRF_IDX_IRQ_ST)
            rdVal = irqStat;
        else if (idx == `WRF_IDX_IRQ_MASK)
            rdVal = irqMask;
        else if (idx >= `WRF_IDX_DATA0 && idx <= `WRF_IDX_DATA9)
            rdVal = dataVec[dataOff[3:0]*16 +: 16];
    end

    always @(posedge clk_sys)
    begin
        if (!rst_b)
            prdata <= 32'h00000000;
        else if (clkEn && psel && !penable)
            prdata <= {16'h0000, mapped ? rdVal : 16'h0000};
    end

    // -----------------------------------------------
    // Frame delimiter and byte tracking
    // -----------------------------------------------
    wire [7:0] rb = reorder(cfg[15:14], rxByte);
    wire [7:0] sfdByte = cfg[`WRF_CFG_SFD] ? `WRF_SFD_SWAPPED : `WRF_SFD_NORMAL;

    reg [1:0] fState;
    reg [1:0] mState;
    reg [2:0] syncCnt;
    reg [2:0] addrPos;
    reg [6:0] bodyCnt;
    reg [2:0] pwCnt;
    reg pwBad;
    reg [3:0] patCnt;
    reg patFail;
    reg [15:0] evt;

    wire inBody = fState == F_BODY;
    wire byteIn = rxByteValid && wolEn;
    wire isSync = rb == `WRF_SYNC_BYTE;
    wire addrHit = rb == macVec[47 - addrPos*8 -: 8];

    // Frame-level state; resets at every frame end
    always @(posedge clk_sys)
    begin
        if (!rst_b)
            fState <= F_HUNT;
        else if (clkEn)
        begin
            if (rxFrameEnd || !wolEn)
                fState <= F_HUNT;
            else if (byteIn)
            begin
                case (fState)
                    F_HUNT:
                        if (rb == sfdByte)
                            fState <= F_BODY;
                        else if (rb != `WRF_PREAMBLE)
                            fState <= F_DROP;
                    default: fState <= fState;
                endcase
            end
        end
    end

    // Magic packet search anywhere in the frame body
    always @(posedge clk_sys)
    begin
        if (!rst_b || !inBody)
        begin
            mState <= M_SYNC;
            syncCnt <= 3'h0;
            addrPos <= 3'h0;
            bodyCnt <= 7'h00;
            pwCnt <= 3'h0;
            pwBad <= 1'b0;
        end
        else if (clkEn && byteIn)
        begin
            case (mState)
                M_SYNC:
                    if (!isSync)
                        syncCnt <= 3'h0;
                    else if (syncCnt == `WRF_SYNC_LAST)
                    begin
                        mState <= M_ADDR;
                        addrPos <= 3'h0;
                        bodyCnt <= 7'h00;
                    end
                    else
                        syncCnt <= syncCnt + 3'h1;
                M_ADDR:
                    if (addrHit)
                    begin
                        addrPos <= (addrPos == `WRF_ADDR_LAST) ? 3'h0 : addrPos + 3'h1;
                        bodyCnt <= bodyCnt + 7'h01;
                        if (bodyCnt == `WRF_BODY_LAST)
                            mState <= cfg[`WRF_CFG_PASS_EN] ? M_PASS : M_DONE;
                    end
                    else if (!(bodyCnt == 7'h00 && isSync))
                    begin
                        // Extra sync bytes before the address are tolerated
                        mState <= M_SYNC;
                        syncCnt <= isSync ? 3'h1 : 3'h0;
                    end
                M_PASS:
                begin
                    if (rb != pwVec[pwCnt*8 +: 8])
                        pwBad <= 1'b1;
                    pwCnt <= pwCnt + 3'h1;
                    if (pwCnt == `WRF_PW_LAST)
                        mState <= M_DONE;
                end
                default: mState <= mState;
            endcase
        end
    end

    // Pattern compare on the leading bytes after the delimiter
    always @(posedge clk_sys)
    begin
        if (!rst_b || !inBody)
        begin
            patCnt <= 4'h0;
            patFail <= 1'b0;
        end
        else if (clkEn && byteIn && patCnt != `WRF_PAT_BYTES)
        begin
            if (rb != patVec[patCnt*8 +: 8])
                patFail <= 1'b1;
            patCnt <= patCnt + 4'h1;
        end
    end

    // -----------------------------------------------
    // Frame verdict events, one cycle each
    // -----------------------------------------------
    wire gated = cfg[`WRF_CFG_CRC_GATE] && rxCrcBad;
    wire magicOk = mState == M_DONE && !pwBad;
    wire hackSeen = cfg[`WRF_CFG_PASS_EN] && (mState == M_PASS || (mState == M_DONE && pwBad));
    wire patOk = patCnt == `WRF_PAT_BYTES && !patFail;
    wire endBody = rxFrameEnd && inBody && wolEn;
    reg [15:0] next_evt;

    always @*
    begin
        next_evt = 16'h0000;
        next_evt[`WRF_ST_SFD_ERR] = byteIn && fState == F_HUNT && rb != sfdByte
            && rb != `WRF_PREAMBLE && !rxFrameEnd;
        next_evt[`WRF_ST_CRC_ERR] = endBody && rxCrcBad;
        next_evt[`WRF_ST_HACK] = endBody && hackSeen;
        next_evt[`WRF_ST_PAT] = endBody && patOk && !gated && cfg[`WRF_CFG_PAT_EN];
        next_evt[`WRF_ST_MAGIC] = endBody && magicOk && !gated && cfg[`WRF_CFG_MAGIC_EN];
    end

    always @(posedge clk_sys)
    begin
        if (!rst_b)
            evt <= 16'h0000;
        else if (clkEn)
            evt <= next_evt;
    end

    // -----------------------------------------------
    // Sticky status and interrupt; set beats clear
    // -----------------------------------------------
    wire stRead = rdDone && idx == `WRF_IDX_ST;
    wire [16:0] irqW1c = {1'b0, (wrEn && idx == `WRF_IDX_IRQ_ST) ? pwdata[15:0] : 16'h0000};

    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rxStat <= 16'h0000;
            irqStat <= 16'h0000;
            irqMask <= 16'h0000;
        end
        else if (clkEn)
        begin
            rxStat <= ((stRead ? 16'h0000 : rxStat) | evt) & `WRF_ST_EVT_MASK;
            irqStat <= ((irqStat & ~irqW1c[15:0]) | evt) & `WRF_ST_EVT_MASK;
            if (wrEn && idx == `WRF_IDX_IRQ_MASK)
                irqMask <= pwdata[15:0] & `WRF_ST_EVT_MASK;
        end
    end

    wire irqNext = |(irqStat & irqMask);

    // Routed output mirrors the selected interrupt source
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            irqOut <= 1'b0;
            intRouteOut <= 1'b0;
        end
        else if (clkEn)
        begin
            irqOut <= irqNext;
            intRouteOut <= srcSel ? irqNext : polarityIrq;
        end
    end

    // -----------------------------------------------
    // Wake indication: level or timed pulse
    // -----------------------------------------------
    wire wakeEvt = evt[`WRF_ST_MAGIC] || evt[`WRF_ST_PAT];
    wire lvlClr = wrEn && idx == `WRF_IDX_CFG && pwdata[`WRF_CFG_LVL_CLR];
    reg [4:0] pulseCnt;

    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wakeOut <= 1'b0;
            pulseCnt <= 5'h00;
        end
        else if (clkEn)
        begin
            if (cfg[`WRF_CFG_IND_SEL])
            begin
                pulseCnt <= 5'h00;
                if (wakeEvt)
                    wakeOut <= 1'b1;
                else if (lvlClr)
                    wakeOut <= 1'b0;
            end
            else if (wakeEvt)
            begin
                pulseCnt <= pulseLen(cfg[10:9]) - 5'h01;
                wakeOut <= 1'b1;
            end
            else if (pulseCnt != 5'h00)
                pulseCnt <= pulseCnt - 5'h01;
            else
                wakeOut <= 1'b0;
        end
    end

endmodule // wrf_wol_rx_filter
`default_nettype wire

// File: verification/wrf_wol_checker.sv
// Assertion checker for the wake-on-LAN receive filter
// Sees only the top ports; assumes clkEn stays high
`timescale 1ns/1ps
`default_nettype none
`include "wrf_consts.vh"

module wrf_wol_checker
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxByteValid,
    input wire logic [7:0] rxByte,
    input wire logic rxFrameEnd,
    input wire logic rxCrcBad,
    input wire logic polarityIrq,
    input wire logic wakeOut,
    input wire logic irqOut,
    input wire logic intRouteOut
);
    // ------------
    // Shadow state
    // ------------
    logic [15:0] cfgSh;
    logic [15:0] maskSh;
    logic srcSh;
    logic [7:0] hiCnt;
    logic [7:0] want;
    logic acc;
    logic cfgWr;

    // Write edges and the pulse length due for the code
    assign acc = psel && penable && pwrite && clkEn;
    assign cfgWr = acc && paddr == {`WRF_IDX_CFG, 2'b00};
    assign want = cfgSh[10] ? (cfgSh[9] ? 8'h15 : 8'h0B) : (cfgSh[9] ? 8'h06 : 8'h03);

    // Mirror only what the outputs depend on
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cfgSh <= 16'h1000;
            maskSh <= 16'h0000;
            srcSh <= 1'b0;
            hiCnt <= 8'h00;
        end
        else
        begin
            hiCnt <= wakeOut ? hiCnt + 8'h01 : 8'h00;
            if (cfgWr)
                cfgSh <= pwdata[15:0];
            if (acc && paddr == {`WRF_IDX_IRQ_MASK, 2'b00})
                maskSh <= pwdata[15:0];
            if (acc && paddr == {`WRF_IDX_ST, 2'b00})
                srcSh <= pwdata[12];
            else if (cfgWr && pwdata[7] && !cfgSh[7])
                srcSh <= 1'b1;
        end
    end

    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // No wake edge in the three cycles a verdict could cause one
    sequence s_noRise;
        ##1 (!$rose(wakeOut)) [*3];
    endsequence

    a_pready_access: assert property (psel && penable |-> pready)
        else $error("pready missing in access");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_pulse_width: assert property ($fell(wakeOut) && !cfgSh[8] |-> hiCnt == want)
        else $error("wake pulse length wrong");
    a_level_hold: assert property (wakeOut && cfgSh[8] && !cfgWr |=> wakeOut)
        else $error("wake level dropped");
    a_level_clear: assert property (cfgWr && pwdata[11] && cfgSh[8] |-> ##[1:2] !wakeOut)
        else $error("wake level not cleared");
    a_wake_gate: assert property ($rose(wakeOut) |-> $past(cfgSh[7], 2))
        else $error("wake while detection off");
    a_wake_timing: assert property ($rose(wakeOut) |-> $past(rxFrameEnd, 2))
        else $error("wake not two cycles after frame end");
    a_crc_gate: assert property (rxFrameEnd && rxCrcBad && cfgSh[12] |-> s_noRise)
        else $error("wake after gated bad frame");
    a_route_wake: assert property ($past(srcSh) && $past(rst_b) |-> intRouteOut == irqOut)
        else $error("route does not follow wake interrupt");
    a_route_pol: assert property (!$past(srcSh) && $past(rst_b) |-> intRouteOut == $past(polarityIrq))
        else $error("route does not follow polarity");
    a_irq_mask: assert property (irqOut && $past(rst_b) |-> $past(maskSh) != 16'h0000)
        else $error("interrupt with all sources masked");
endmodule // wrf_wol_checker

bind wrf_wol_rx_filter wrf_wol_checker i_wrf_wol_checker (.*);

`default_nettype wire

// File: verification/wrf_mac_src.sv
// Frame source standing in for the receive datapath
// Bytes one per clock; idle data shows the inverted last byte
`timescale 1ns/1ps
`default_nettype none

module wrf_mac_src
(
    input wire logic clk_sys,
    output var logic rxByteValid,
    output var logic [7:0] rxByte,
    output var logic rxFrameEnd,
    output var logic rxCrcBad
);
    logic [7:0] q [$];
    logic [1:0] order = 2'b00;

    // Idle values at time zero
    initial
    begin
        rxByteValid = 1'b0;
        rxByte = 8'h00;
        rxFrameEnd = 1'b0;
        rxCrcBad = 1'b0;
    end

    // Undo the receive ordering so the filter sees b after reorder
    task put(input logic [7:0] b);
        case (order)
            2'b01: q.push_back({b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]});
            2'b10: q.push_back({b[3:0], b[7:4]});
            2'b11: q.push_back({b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]});
            default: q.push_back(b);
        endcase
    endtask

    // Send the queue, then the frame end with its verdict
    task go(input logic bad);
        while (q.size() > 0)
        begin
            @(posedge clk_sys);
            rxByteValid <= 1'b1;
            rxByte <= q.pop_front();
        end
        @(posedge clk_sys);
        rxByteValid <= 1'b0;
        rxByte <= ~rxByte;
        rxFrameEnd <= 1'b1;
        rxCrcBad <= bad;
        @(posedge clk_sys);
        rxFrameEnd <= 1'b0;
        rxCrcBad <= ~bad;
    endtask
endmodule // wrf_mac_src

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the wake-on-LAN receive filter
// Drives APB and a frame source; clkEn stays high
`timescale 1ns/1ps
`default_nettype none
`include "wrf_consts.vh"

module tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic polarityIrq = 1'b0;
    logic pready, pslverr, wakeOut, irqOut, intRouteOut, lastErr;
    logic rxByteValid, rxFrameEnd, rxCrcBad;
    logic [7:0] rxByte;
    logic [31:0] prdata;
    logic [15:0] rdv;
    int failures = 0;
    int tests_run = 0;
    // Address, password and pattern words from index 0x04A2 up
    logic [15:0] dataInit [10] = '{16'h3435, 16'h3233, 16'h3031, 16'h6160, 16'h6362,
        16'h6564, 16'hA1A0, 16'hA3A2, 16'hA5A4, 16'hA7A6};

    always #12.5 clk_sys = ~clk_sys;

    wrf_wol_rx_filter i_wrf_wol_rx_filter (.*);
    wrf_mac_src i_wrf_mac_src (.clk_sys(clk_sys), .rxByteValid(rxByteValid), .rxByte(rxByte),
        .rxFrameEnd(rxFrameEnd), .rxCrcBad(rxCrcBad));

    // -------------
    // Bench tasks
    // -------------
    task end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [13:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 20)
        begin
            failures++;
            $display("wrong value at %0t: no pready", $time);
            end_sim;
        end
        rdv = prdata[15:0];
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [13:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(rdv, exp);
    endtask

    // Kinds: 0 magic, 1 good password, 2 bad password, 3 pattern, 4 broken delimiter
    task automatic frame(input logic [15:0] c, input int kind, input logic bad);
        i_wrf_mac_src.order = c[15:14];
        repeat (2) i_wrf_mac_src.put(8'h55);
        i_wrf_mac_src.put(kind == 4 ? 8'h12 : (c[13] ? 8'h5D : 8'hD5));
        if (kind == 3)
            for (int i = 0; i < 8; i++) i_wrf_mac_src.put(8'hA0 + 8'(i));
        else
        begin
            repeat (6) i_wrf_mac_src.put(8'hFF);
            for (int i = 0; i < 96; i++) i_wrf_mac_src.put(8'h30 + 8'(i % 6));
            if (kind == 1 || kind == 2)
                for (int i = 0; i < 6; i++) i_wrf_mac_src.put(8'h60 + 8'(i) ^ {7'h00, kind == 2 && i == 5});
        end
        i_wrf_mac_src.go(bad);
    endtask

    // Frame, then interrupt, status, clear on read and W1C
    task automatic step(input logic [15:0] c, input int kind, input logic bad, input logic [15:0] st);
        apb(1'b1, `WRF_IDX_CFG, c);
        frame(c, kind, bad);
        repeat (3) @(posedge clk_sys);
        chk({15'h0000, irqOut}, {15'h0000, |st[1:0]});
        rdChk(`WRF_IDX_ST, st);
        rdChk(`WRF_IDX_ST, st & 16'h1000);
        apb(1'b1, `WRF_IDX_IRQ_ST, 16'h00E3);
        repeat (2) @(posedge clk_sys);
        chk({15'h0000, irqOut}, 16'h0000);
        repeat (10) @(posedge clk_sys);
    endtask

    // -------------
    // Main sequence
    // -------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdChk(`WRF_IDX_CFG, 16'h1000);
        rdChk(`WRF_IDX_ST, 16'h0000);
        rdChk(14'h04BF, 16'h0000);
        chk({15'h0000, lastErr}, 16'h0001);
        for (int i = 0; i < 10; i++)
        begin
            rdChk(`WRF_IDX_DATA0 + 14'(i), 16'h0000);
            apb(1'b1, `WRF_IDX_DATA0 + 14'(i), dataInit[i]);
            rdChk(`WRF_IDX_DATA0 + 14'(i), dataInit[i]);
        end
        apb(1'b1, `WRF_IDX_IRQ_MASK, 16'h0003);
        for (int m = 0; m < 4; m++)
            step({2'(m), m[0], 2'b10, 2'(m), 2'b01, 7'h01}, 0, 1'b0, 16'h1001);
        step(16'h1081, 4, 1'b0, 16'h1080);
        step(16'h1081, 0, 1'b1, 16'h1040);
        step(16'h0081, 0, 1'b1, 16'h1041);
        step(16'h10A1, 1, 1'b0, 16'h1001);
        step(16'h10A1, 2, 1'b0, 16'h1020);
        step(16'h1082, 3, 1'b0, 16'h1002);
        step(16'h1181, 0, 1'b0, 16'h1001);
        chk({15'h0000, wakeOut}, 16'h0001);
        apb(1'b1, `WRF_IDX_CFG, 16'h1981);
        repeat (2) @(posedge clk_sys);
        chk({15'h0000, wakeOut}, 16'h0000);
        step(16'h1001, 0, 1'b0, 16'h1000);
        apb(1'b1, `WRF_IDX_ST, 16'h00E3);
        rdChk(`WRF_IDX_ST, 16'h0000);
        polarityIrq <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({15'h0000, intRouteOut}, 16'h0001);
        polarityIrq <= 1'b0;
        apb(1'b1, `WRF_IDX_CFG, 16'h1081);
        rdChk(`WRF_IDX_ST, 16'h1000);
        end_sim;
    end
endmodule // tb_top

`default_nettype wire
